// file: verif/prog_mem_model.sv
// behavioural program memory that answers the core's fetch address
module prog_mem_model (
	// fetch side
	input  wire logic [8:0]  prog_addr,
	output logic [11:0]      prog_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// 512 words of 12 bits, loaded by the bench before each run
	logic [11:0] mem [0:511];

	// asynchronous read: the core samples the word at its fetch phase, so no latency is modelled
	assign prog_data = mem[prog_addr];
endmodule // prog_mem_model

// file: verif/tb_top.sv
// self-checking bench for the instruction decoder core over apb
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// dut signals
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [8:0]  prog_addr;
	logic [11:0] prog_data;
	logic        wb_to_w;
	logic        wb_to_file;
	int          bad_count  = 0;
	int          n_compared = 0;
	logic [31:0] q;
	logic        err;
	logic [11:0] words [0:4] = '{12'h1C5, 12'h3FF, 12'h5E3, 12'hC5A, 12'hA33};

	// 250 MHz clock
	always #2 pclk = ~pclk;

	instruction_format_decode dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data), .wb_to_w(wb_to_w),
		.wb_to_file(wb_to_file));
	prog_mem_model pm_u (.prog_addr(prog_addr), .prog_data(prog_data));

	// one apb transfer, entered in the time step of a rising edge; an idle cycle follows
	// so that back to back calls never drive psel twice in one time step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic e);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask

	// core runs for exactly gap rising edges: run is set at one access edge and cleared at another
	task automatic run_for(input int gap);
		reg_wr(ifd_pkg::A_CTRL, 32'h1);
		repeat (gap - 3) @(posedge pclk);
		reg_wr(ifd_pkg::A_CTRL, 32'h0);
	endtask

	// reset pulse, also used mid-run to restart the program counter
	task automatic reset_dut();
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask

	// memory holds one word everywhere; a test then writes any short program at the bottom
	task automatic fill(input logic [11:0] w);
		for (int i = 0; i < 512; i++) pm_u.mem[i] = w;
	endtask

	// expected decode register contents from the field layout
	function automatic logic [31:0] dec(input logic [11:0] w);
		logic [31:0] r;
		r        = 32'h0;
		r[0]     = (w[11:10] == 2'h0);
		r[1]     = (w[11:10] == 2'h1);
		r[2]     = w[11];
		r[3]     = (w[11:9] == 3'h5);
		r[4]     = w[5];
		r[9:5]   = w[4:0];
		r[12:10] = w[7:5];
		r[24:16] = w[8:0];
		return r;
	endfunction

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// watchdog far beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		results();
	end

	initial begin
		fill(12'h000);
		reset_dut();
		reg_rd(ifd_pkg::A_CTRL, q);
		`CHK(q, 32'h0)
		reg_rd(ifd_pkg::A_STATUS, q);
		`CHK(q, 32'h200)
		reg_wr(ifd_pkg::A_STATUS, 32'hFFFFFFFF);
		reg_rd(ifd_pkg::A_STATUS, q);
		`CHK(q, 32'h200)
		apb(1'b0, 8'h18, 32'h0, q, err);
		`CHK(err, 1'b1)
		`CHK(q, 32'h0)
		$display("test registers done");
		// nop stream: twelve edges give three fetches, seven more give one more
		run_for(12);
		reg_rd(ifd_pkg::A_STATUS, q);
		`CHK(q, 32'h003)
		reg_rd(ifd_pkg::A_CYCLES, q);
		`CHK(q, 32'h3)
		run_for(7);
		reg_rd(ifd_pkg::A_STATUS, q);
		`CHK(q, 32'h004)
		$display("test timing done");
		// jump at address 0 to 5 costs a flushed second cycle
		pm_u.mem[0] = 12'hA05;
		reset_dut();
		run_for(8);
		reg_rd(ifd_pkg::A_STATUS, q);
		`CHK(q, 32'h205)
		run_for(4);
		reg_rd(ifd_pkg::A_STATUS, q);
		`CHK(q, 32'h006)
		`CHK(prog_addr, 9'h006)
		$display("test jump done");
		// force bit 7 of file 3, skip if set flushes a force of file 4 bit 0, skip if clear another
		fill(12'h000);
		pm_u.mem[0] = 12'h5E3;
		pm_u.mem[1] = 12'h7E3;
		pm_u.mem[2] = 12'h504;
		pm_u.mem[3] = 12'h604;
		pm_u.mem[4] = 12'h504;
		reset_dut();
		reg_wr(ifd_pkg::A_FSEL, 32'h4);
		reg_wr(ifd_pkg::A_FDATA, 32'h0);
		reg_wr(ifd_pkg::A_FSEL, 32'h3);
		reg_wr(ifd_pkg::A_FDATA, 32'h0A);
		run_for(8);
		reg_rd(ifd_pkg::A_FDATA, q);
		`CHK(q, 32'h8A)
		reg_rd(ifd_pkg::A_STATUS, q);
		`CHK(q, 32'h07E30002)
		run_for(4);
		reg_rd(ifd_pkg::A_STATUS, q);
		`CHK(q, 32'h05040203)
		run_for(4);
		reg_rd(ifd_pkg::A_STATUS, q);
		`CHK(q, 32'h06040004)
		run_for(4);
		reg_rd(ifd_pkg::A_STATUS, q);
		`CHK(q, 32'h05040205)
		run_for(4);
		reg_rd(ifd_pkg::A_STATUS, q);
		`CHK(q, 32'h006)
		reg_wr(ifd_pkg::A_FSEL, 32'h4);
		reg_rd(ifd_pkg::A_FDATA, q);
		`CHK(q, 32'h0)
		$display("test bit force and skip done");
		// each format with memory full of one word, so the executing word is known
		for (int i = 0; i < 5; i++) begin
			fill(words[i]);
			reg_wr(ifd_pkg::A_CTRL, 32'h1);
			repeat (8) @(posedge pclk);
			// steering is looked at mid cycle, where it has settled, never at its launching edge
			@(negedge pclk);
			`CHK(wb_to_w, (words[i][11:10] == 2'h0) & ~words[i][5])
			`CHK(wb_to_file, (words[i][11:10] == 2'h0) & words[i][5])
			@(posedge pclk);
			reg_wr(ifd_pkg::A_CTRL, 32'h0);
			reg_rd(ifd_pkg::A_DECODE, q);
			`CHK(q, dec(words[i]))
		end
		$display("test formats done");
		results();
	end
endmodule // tb_top

// file: verilog/ifd_field_decode.sv
// combinational split of a 12-bit instruction word into its fields
module ifd_field_decode (
	// instruction word
	input  wire logic [11:0] instr,
	// instruction class
	output logic             is_byte,
	output logic             is_bit,
	output logic             is_lit,
	output logic             is_jump,
	// fields
	output logic [5:0]       op_byte,
	output logic [3:0]       op_short,
	output logic [2:0]       op_jump,
	output logic             dest_file,
	output logic [4:0]       faddr,
	output logic [2:0]       bitnum,
	output logic [7:0]       bit_mask,
	output logic [7:0]       lit8,
	output logic [8:0]       lit9
);
	// class from the top bits only, so operand or don't-care bits never move it
	always_comb begin
		is_byte = (instr[ifd_pkg::OP_HI -: 2] == ifd_pkg::CLS_BYTE); // RQ11
		is_bit  = (instr[ifd_pkg::OP_HI -: 2] == ifd_pkg::CLS_BIT); // RQ11
		is_lit  = !is_byte && !is_bit;
		is_jump = (instr[ifd_pkg::OP_HI:ifd_pkg::JMP_LO] == ifd_pkg::JMP_CODE); // RQ8
	end

	// operand fields by position
	assign op_byte   = instr[ifd_pkg::OP_HI:ifd_pkg::BYTE_LO]; // RQ4
	assign dest_file = instr[ifd_pkg::DEST_BIT]; // RQ2
	assign faddr     = instr[ifd_pkg::FA_HI:0]; // RQ3
	assign op_short  = instr[ifd_pkg::OP_HI:ifd_pkg::BIT_LO]; // RQ5
	assign bitnum    = instr[ifd_pkg::BN_HI:ifd_pkg::BN_LO]; // RQ5
	assign bit_mask  = 8'h01 << bitnum; // RQ6
	assign lit8      = instr[ifd_pkg::LIT_HI:0]; // RQ7
	assign op_jump   = instr[ifd_pkg::OP_HI:ifd_pkg::JMP_LO]; // RQ8
	assign lit9      = instr[ifd_pkg::JK_HI:0]; // RQ8
endmodule // ifd_field_decode

// file: verilog/ifd_pkg.sv
// constants shared by the instruction decoder and its core wrapper
package ifd_pkg;
	// instruction word and field widths
	localparam int IW       = 12;
	localparam int FAW      = 5;
	localparam int BNW      = 3;
	localparam int DW       = 8;
	localparam int PCW      = 9;
	localparam int NFILE    = 32;
	localparam logic [FAW-1:0] FILE_LAST = 5'h1F;
	// field positions
	localparam int OP_HI    = 11;
	localparam int BYTE_LO  = 6;
	localparam int DEST_BIT = 5;
	localparam int FA_HI    = 4;
	localparam int BIT_LO   = 8;
	localparam int BN_HI    = 7;
	localparam int BN_LO    = 5;
	localparam int LIT_LO   = 8;
	localparam int LIT_HI   = 7;
	localparam int JMP_LO   = 9;
	localparam int JK_HI    = 8;
	// class codes in bits 11:10, jump code in bits 11:9
	localparam logic [1:0] CLS_BYTE = 2'h0;
	localparam logic [1:0] CLS_BIT  = 2'h1;
	localparam logic [2:0] JMP_CODE = 3'h5;
	// bit-oriented opcodes in bits 11:8
	localparam logic [3:0] OP_FORCE1 = 4'h5;
	localparam logic [3:0] OP_SKIPCLR = 4'h6;
	localparam logic [3:0] OP_SKIPSET = 4'h7;
	localparam logic [IW-1:0] NOP_WORD = 12'h000;
	// instruction cycle phases, one per clock
	typedef enum logic [3:0] {
		PH1 = 4'h1,
		PH2 = 4'h2,
		PH3 = 4'h4,
		PH4 = 4'h8
	} phase_e;
	// register byte addresses
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_DECODE = 8'h08;
	localparam logic [7:0] A_FSEL   = 8'h0C;
	localparam logic [7:0] A_FDATA  = 8'h10;
	localparam logic [7:0] A_CYCLES = 8'h14;
	// register field positions
	localparam int CTRL_RUN  = 0;
	localparam int ST_FLUSH  = 9;
	localparam int ST_IR_LO  = 16;
	localparam int DC_CLS_LO = 0;
	localparam int DC_JUMP   = 3;
	localparam int DC_DEST   = 4;
	localparam int DC_FA_LO  = 5;
	localparam int DC_BN_LO  = 10;
	localparam int DC_K_LO   = 16;
	localparam logic CTRL_RESET = 1'b0;
endpackage : ifd_pkg

// file: verilog/instruction_format_decode.sv
// instruction fetch, decode and timing core with an apb register window
// How it works
// [RQ1] each instruction is fetched and decoded as one 12-bit word of opcode and operand fields.
// [RQ2] in byte operations a destination bit of zero sends the result to the accumulator, one to the file register.
// [RQ3] the file field picks one of 32 file registers, addresses 0x00 to 0x1F.
// [RQ4] byte operations take opcode from bits 11:6, destination from bit 5, file address from bits 4:0.
// [RQ5] bit operations take opcode from bits 11:8, bit number from bits 7:5, file address from bits 4:0.
// [RQ6] the bit number picks one bit of the addressed 8-bit file register.
// [RQ7] literal operations other than the jump take opcode from bits 11:8 and an 8-bit literal from bits 7:0.
// [RQ8] the jump takes opcode from bits 11:9 and a 9-bit target from bits 8:0.
// [RQ9] an instruction takes one cycle, or two when a test is true or the program counter changes.
// [RQ10] one instruction cycle is four consecutive clock periods.
// [RQ11] don't-care bits never change the decoded operation.
// [RQ12] the bit force one instruction sets the chosen bit, touches no status flag, and takes one cycle.
//
// Implementation choices: register access over APB and the register offsets.
module instruction_format_decode (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// program memory
	output logic [8:0]       prog_addr,
	input  wire logic [11:0] prog_data,
	// decoded destination of the executing byte operation
	output logic             wb_to_w,
	output logic             wb_to_file
);
	logic                 run;
	logic [4:0]           fsel;
	logic [31:0]          cycles;
	logic [8:0]           pc;
	logic [11:0]          ir;
	logic                 flush;
	ifd_pkg::phase_e      phase;
	ifd_pkg::phase_e      next_phase;
	logic [7:0]           file [ifd_pkg::NFILE];
	logic                 is_byte;
	logic                 is_bit;
	logic                 is_lit;
	logic                 is_jump;
	logic [5:0]           op_byte;
	logic [3:0]           op_short;
	logic [2:0]           op_jump;
	logic                 dest_file;
	logic [4:0]           faddr;
	logic [2:0]           bitnum;
	logic [7:0]           bit_mask;
	logic [7:0]           lit8;
	logic [8:0]           lit9;
	logic                 live;
	logic                 do_force1;
	logic                 test_true;
	logic                 end_cycle;
	logic                 apb_wr;
	logic                 apb_setup;
	logic                 addr_ok;
	logic [31:0]          rd_mux;

	ifd_field_decode u_dec (
		.instr     (ir),
		.is_byte   (is_byte),
		.is_bit    (is_bit),
		.is_lit    (is_lit),
		.is_jump   (is_jump),
		.op_byte   (op_byte),
		.op_short  (op_short),
		.op_jump   (op_jump),
		.dest_file (dest_file),
		.faddr     (faddr),
		.bitnum    (bitnum),
		.bit_mask  (bit_mask),
		.lit8      (lit8),
		.lit9      (lit9)
	);

	// a flushed word is the one fetched behind a taken skip or jump
	assign live      = !flush;
	assign end_cycle = run && (phase == ifd_pkg::PH4);
	assign do_force1 = live && is_bit && (op_short == ifd_pkg::OP_FORCE1); // RQ12
	// bit tests read the addressed register through the bit mask
	always_comb begin
		test_true = 1'b0;
		if (live && is_bit && (op_short == ifd_pkg::OP_SKIPCLR)) begin
			test_true = ((file[faddr] & bit_mask) == 8'h00); // RQ6
		end else if (live && is_bit && (op_short == ifd_pkg::OP_SKIPSET)) begin
			test_true = ((file[faddr] & bit_mask) != 8'h00); // RQ6
		end
	end

	// destination steering for byte operations
	assign wb_to_w    = live && is_byte && !dest_file; // RQ2
	assign wb_to_file = live && is_byte && dest_file; // RQ2
	assign prog_addr  = pc;

	// four phases per instruction cycle, held while stopped
	always_comb begin
		next_phase = phase;
		if (run) begin
			case (phase)
				ifd_pkg::PH1: next_phase = ifd_pkg::PH2; // RQ10
				ifd_pkg::PH2: next_phase = ifd_pkg::PH3; // RQ10
				ifd_pkg::PH3: next_phase = ifd_pkg::PH4; // RQ10
				ifd_pkg::PH4: next_phase = ifd_pkg::PH1; // RQ10
				default:      next_phase = ifd_pkg::PH1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= ifd_pkg::PH1;
		end else begin
			phase <= next_phase;
		end
	end

	// fetch the whole word at the last phase; jumps load the target
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc <= '0;
			ir <= ifd_pkg::NOP_WORD;
		end else if (end_cycle) begin
			ir <= prog_data; // RQ1
			if (live && is_jump) begin
				pc <= lit9; // RQ8
			end else begin
				pc <= pc + 9'h001;
			end
		end
	end

	// a true test or a pc change turns the next word into a nop: two cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flush <= 1'b1;
		end else if (end_cycle) begin
			flush <= live && (test_true || is_jump); // RQ9
		end
	end

	// instruction cycles elapsed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycles <= '0;
		end else if (end_cycle) begin
			cycles <= cycles + 32'h0000_0001;
		end
	end

	// file bank; the core's bit force lands after a same-cycle bus write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < ifd_pkg::NFILE; i++) begin
				file[i] <= 8'h00;
			end
		end else begin
			if (apb_wr && (paddr == ifd_pkg::A_FDATA)) begin
				file[fsel] <= pwdata[ifd_pkg::DW-1:0];
			end
			if (end_cycle && do_force1) begin
				file[faddr][bitnum] <= 1'b1; // RQ12
			end
		end
	end

	// apb: no wait state; read data comes from a flop loaded in the setup phase
	assign apb_setup = psel && !penable;
	assign pready    = psel && penable;
	assign apb_wr    = psel && penable && pwrite;
	always_comb begin
		addr_ok = (paddr == ifd_pkg::A_CTRL) || (paddr == ifd_pkg::A_STATUS) ||
			(paddr == ifd_pkg::A_DECODE) || (paddr == ifd_pkg::A_FSEL) ||
			(paddr == ifd_pkg::A_FDATA) || (paddr == ifd_pkg::A_CYCLES);
	end
	assign pslverr = pready && !addr_ok;

	// read mux; status and decode are read only
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (paddr == ifd_pkg::A_CTRL) begin
			rd_mux[ifd_pkg::CTRL_RUN] = run;
		end else if (paddr == ifd_pkg::A_STATUS) begin
			rd_mux[ifd_pkg::PCW-1:0] = pc;
			rd_mux[ifd_pkg::ST_FLUSH] = flush;
			rd_mux[ifd_pkg::ST_IR_LO +: ifd_pkg::IW] = ir;
		end else if (paddr == ifd_pkg::A_DECODE) begin
			rd_mux[ifd_pkg::DC_CLS_LO +: 3] = {is_lit, is_bit, is_byte};
			rd_mux[ifd_pkg::DC_JUMP] = is_jump;
			rd_mux[ifd_pkg::DC_DEST] = dest_file;
			rd_mux[ifd_pkg::DC_FA_LO +: ifd_pkg::FAW] = faddr;
			rd_mux[ifd_pkg::DC_BN_LO +: ifd_pkg::BNW] = bitnum;
			rd_mux[ifd_pkg::DC_K_LO +: ifd_pkg::PCW] = lit9;
		end else if (paddr == ifd_pkg::A_FSEL) begin
			rd_mux[ifd_pkg::FAW-1:0] = fsel;
		end else if (paddr == ifd_pkg::A_FDATA) begin
			rd_mux[ifd_pkg::DW-1:0] = file[fsel];
		end else if (paddr == ifd_pkg::A_CYCLES) begin
			rd_mux = cycles;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (apb_setup && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// software control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run  <= ifd_pkg::CTRL_RESET;
			fsel <= '0;
		end else if (apb_wr) begin
			if (paddr == ifd_pkg::A_CTRL) begin
				run <= pwdata[ifd_pkg::CTRL_RUN];
			end else if (paddr == ifd_pkg::A_FSEL) begin
				fsel <= pwdata[ifd_pkg::FAW-1:0];
			end
		end
	end

	// checks
	property p_fetch;
		@(posedge pclk) disable iff (!presetn)
		end_cycle |=> (ir == $past(prog_data));
	endproperty
	a_fetch: assert property (p_fetch) else $error("word not fetched whole"); // RQ1

	property p_dest;
		@(posedge pclk) disable iff (!presetn)
		(live && is_byte) |-> (wb_to_file == ir[ifd_pkg::DEST_BIT]) && (wb_to_w != wb_to_file);
	endproperty
	a_dest: assert property (p_dest) else $error("destination steering wrong"); // RQ2

	property p_byte_fields;
		@(posedge pclk) disable iff (!presetn)
		is_byte |-> (op_byte == ir[11:6]) && (faddr == ir[4:0]) && (faddr <= ifd_pkg::FILE_LAST);
	endproperty
	a_byte_fields: assert property (p_byte_fields) else $error("byte fields wrong"); // RQ4

	property p_bit_fields;
		@(posedge pclk) disable iff (!presetn)
		is_bit |-> (op_short == ir[11:8]) && (bitnum == ir[7:5]) && (bit_mask[bitnum]) && $onehot(bit_mask);
	endproperty
	a_bit_fields: assert property (p_bit_fields) else $error("bit fields wrong"); // RQ5

	property p_lit_fields;
		@(posedge pclk) disable iff (!presetn)
		(is_lit && !is_jump) |-> (lit8 == ir[7:0]) && $onehot({is_byte, is_bit, is_lit});
	endproperty
	a_lit_fields: assert property (p_lit_fields) else $error("literal fields wrong"); // RQ7

	property p_jump;
		@(posedge pclk) disable iff (!presetn)
		(end_cycle && live && is_jump) |=> (pc == $past(lit9)) && flush;
	endproperty
	a_jump: assert property (p_jump) else $error("jump target not loaded"); // RQ8

	property p_single;
		@(posedge pclk) disable iff (!presetn)
		(end_cycle && (!live || (!is_jump && !test_true))) |=> !flush;
	endproperty
	a_single: assert property (p_single) else $error("spurious second cycle"); // RQ9

	property p_four;
		@(posedge pclk) disable iff (!presetn)
		(run && phase == ifd_pkg::PH1) ##1 run [*3] |=> (phase == ifd_pkg::PH1);
	endproperty
	a_four: assert property (p_four) else $error("instruction cycle not four clocks"); // RQ10

	// checker helper: address of the word that just executed, kept one clock so the
	// result of a force can still be read after ir has moved on to the next word
	logic [4:0]           force_addr_q;
	logic [7:0]           force_byte;
	logic [7:0]           force_now;
	assign force_byte = file[faddr];
	assign force_now  = file[force_addr_q];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_addr_q <= '0;
		end else begin
			force_addr_q <= faddr;
		end
	end

	property p_force1;
		@(posedge pclk) disable iff (!presetn)
		(end_cycle && do_force1 && !apb_wr) |=>
			(force_now == ($past(force_byte) | $past(bit_mask))) && !flush;
	endproperty
	a_force1: assert property (p_force1) else $error("bit force one wrong"); // RQ12

	property p_freeze;
		@(posedge pclk) disable iff (!presetn)
		!run |=> $stable(phase) && $stable(pc) && $stable(ir);
	endproperty
	a_freeze: assert property (p_freeze) else $error("core moved while stopped"); // RQ10

	property p_cycles;
		@(posedge pclk) disable iff (!presetn)
		end_cycle |=> (cycles == $past(cycles) + 32'h0000_0001);
	endproperty
	a_cycles: assert property (p_cycles) else $error("cycle count not advanced"); // RQ10

	property p_pc_step;
		@(posedge pclk) disable iff (!presetn)
		(end_cycle && !(live && is_jump)) |=> (pc == $past(pc) + 9'h001);
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc did not step one word"); // RQ1

	property p_skip_true;
		@(posedge pclk) disable iff (!presetn)
		(end_cycle && test_true) |=> flush;
	endproperty
	a_skip_true: assert property (p_skip_true) else $error("true test did not take two cycles"); // RQ9

	property p_test_bit;
		@(posedge pclk) disable iff (!presetn)
		(live && is_bit && ((op_short == ifd_pkg::OP_SKIPCLR) || (op_short == ifd_pkg::OP_SKIPSET))) |->
			(test_true == (file[faddr][bitnum] == op_short[0]));
	endproperty
	a_test_bit: assert property (p_test_bit) else $error("bit test read wrong bit"); // RQ6

	property p_nop;
		@(posedge pclk) disable iff (!presetn)
		!live |-> !wb_to_w && !wb_to_file && !do_force1 && !test_true;
	endproperty
	a_nop: assert property (p_nop) else $error("flushed word had an effect"); // RQ9

	property p_jump_fields;
		@(posedge pclk) disable iff (!presetn)
		is_jump |-> is_lit && (op_jump == ifd_pkg::JMP_CODE) && (lit9 == ir[8:0]);
	endproperty
	a_jump_fields: assert property (p_jump_fields) else $error("jump fields wrong"); // RQ8

	property p_class;
		@(posedge pclk) disable iff (!presetn)
		(is_byte == (ir[11:10] == 2'h0)) && (is_bit == (ir[11:10] == 2'h1)) && (is_jump == (ir[11:9] == 3'h5));
	endproperty
	a_class: assert property (p_class) else $error("class moved by operand bits"); // RQ11
endmodule // instruction_format_decode
